// file: gsf_pkg.sv
// Shared constants, frame layout and status types for the rate sensor SPI frontend.
// Assumes a 32-bit SPI mode 0 frame, MSB first, with an off-frame response.
package gsf_pkg;

	localparam int          FRAME_BITS       = 32;
	localparam int          CRC_BITS         = 8;
	localparam int          CRC_SPAN         = FRAME_BITS - CRC_BITS;
	localparam logic [7:0]  CRC_POLY         = 8'h1D;
	localparam logic [7:0]  CRC_INIT         = 8'hFF;
	localparam logic [7:0]  CRC_XOR_OUT      = 8'hFF;
	localparam logic [7:0]  CRC_TOP_BIT      = 8'h80;

	localparam logic [5:0]  BIT_CNT_LAST     = 6'h1F;
	localparam logic [5:0]  BIT_CNT_FULL     = 6'h20;
	localparam logic [5:0]  BIT_CNT_MAX      = 6'h21;

	localparam logic [4:0]  ADDR_RATE        = 5'h01;
	localparam logic [4:0]  ADDR_TEMP        = 5'h07;
	localparam logic [4:0]  ADDR_ACC_STATUS  = 5'h15;
	// Addresses that exist anywhere in the device; others are reserved
	localparam logic [31:0] ADDR_EXISTS_MASK = 32'h8B600682;

	localparam logic [15:0] DATA_RESET       = 16'h0000;
	localparam logic [2:0]  OK_RESET         = 3'h0;

	typedef enum logic [1:0] {
		RS_INIT   = 2'h0,
		RS_NORMAL = 2'h1,
		RS_SELFTEST = 2'h2,
		RS_ERROR  = 2'h3
	} gsf_rs_e;

	typedef struct packed {
		logic        wr;
		logic [4:0]  addr;
		logic [1:0]  return_status_field;
		logic [15:0] data;
		logic [7:0]  crc;
	} gsf_frame_s;

	typedef struct packed {
		logic ok_common;
		logic ok_rate;
		logic ok_acc;
	} gsf_ok_s;

endpackage : gsf_pkg

// file: gsf_crc8.sv
// Combinational CRC-8 over the upper 24 bits of a frame.
// Assumes the caller registers the result where timing needs it.
`timescale 1ns/10ps
module gsf_crc8
	import gsf_pkg::*;
(
	input  wire logic [CRC_SPAN-1:0] data_in,
	output logic      [7:0]          crc_out
);

	always_comb begin
		logic [7:0] crc;
		logic       fb;
		crc = CRC_INIT;
		fb  = 1'b0;
		for (int i = CRC_SPAN - 1; i >= 0; i--) begin
			fb  = ((crc & CRC_TOP_BIT) != 8'h00) ^ data_in[i];
			crc = {crc[6:0], 1'b0};
			if (fb) begin
				crc = crc ^ CRC_POLY;
			end
		end
		crc_out = crc ^ CRC_XOR_OUT;
	end

endmodule : gsf_crc8

// file: gsf_frontend.sv
// SPI slave frame logic of a single-axis rate sensor: return status, CRC and output registers.
// Assumes SPI mode 0, spi_clk_in idles low and only runs while cs_n_in is low,
// and at least eight clk_sys_in cycles pass between the rise of cs_n_in and the next SPI clock edge.
`timescale 1ns/10ps
module gsf_frontend
	import gsf_pkg::*;
#(
	parameter int COMMON_FLAGS = 8,
	parameter int RATE1_FLAGS  = 8,
	parameter int RATE2_FLAGS  = 8,
	parameter int ACC_FLAGS    = 8
) (
	input  wire logic                    clk_sys_in,
	input  wire logic                    reset_in,
	// SPI pins; the SPI clock clocks the link side
	input  wire logic                    spi_clk_in,
	input  wire logic                    cs_n_in,
	input  wire logic                    mosi_in,
	output logic                         miso_out,
	// Sensor side, same clock as clk_sys_in
	input  wire logic [15:0]             angular_rate_in,
	input  wire logic [15:0]             temperature_in,
	input  wire logic                    init_busy_in,
	input  wire logic                    self_test_in,
	input  wire logic [COMMON_FLAGS-1:0] common_ok_flags_in,
	input  wire logic [RATE1_FLAGS-1:0]  rate1_ok_flags_in,
	input  wire logic [RATE2_FLAGS-1:0]  rate2_ok_flags_in,
	input  wire logic [ACC_FLAGS-1:0]    acc_ok_flags_in,
	output logic                         write_strobe_out,
	output logic [4:0]                   write_addr_out,
	output logic [15:0]                  write_data_out,
	output logic [2:0]                   status_ok_out,
	output logic                         crc_error_out
);

	// Link domain, one state per clock edge kind
	typedef struct packed {
		logic [31:0] shift;
		logic [30:0] tx;
		gsf_frame_s  frame;
		logic        full;
	} gsf_link_s;

	// System domain state
	typedef struct packed {
		logic [1:0]  cs_sync;
		logic        cs_prev;
		logic        pend;
		gsf_frame_s  req;
		logic [23:0] body;
		gsf_frame_s  resp;
		logic        wr_stb;
		logic [4:0]  wr_addr;
		logic [15:0] wr_data;
		gsf_ok_s     ok;
		logic        crc_err;
	} gsf_sys_s;

	gsf_link_s  link_r;
	gsf_link_s  link_nxt;
	logic [5:0] bit_cnt_r;
	logic       miso_r;
	gsf_sys_s   sys_r;
	gsf_sys_s   sys_nxt;
	logic [7:0] req_crc;
	logic [7:0] resp_crc;

	function automatic logic [4:0] tx_index(input logic [5:0] cnt);
		logic [5:0] idx;
		idx = BIT_CNT_LAST - cnt;
		return idx[4:0];
	endfunction : tx_index

	function automatic logic addr_exists(input logic [4:0] addr);
		return ADDR_EXISTS_MASK[addr];
	endfunction : addr_exists

	// Highest of self-test, init, error and normal wins
	function automatic gsf_rs_e status_code(
		input logic st,
		input logic busy,
		input logic fault
	);
		gsf_rs_e code;
		if (st) begin
			code = RS_SELFTEST;
		end else if (busy) begin
			code = RS_INIT;
		end else if (fault) begin
			code = RS_ERROR;
		end else begin
			code = RS_NORMAL;
		end
		return code;
	endfunction : status_code

	// Only the acceleration status address belongs to the acceleration channel
	function automatic logic channel_fault(
		input logic [4:0] addr,
		input gsf_ok_s    ok
	);
		logic acc_chan;
		acc_chan = (addr == ADDR_ACC_STATUS);
		return !ok.ok_common
			|| (!acc_chan && !ok.ok_rate)
			|| (acc_chan && !ok.ok_acc);
	endfunction : channel_fault

	// Writes and all other addresses answer with zero data
	function automatic logic [15:0] read_word(
		input logic        wr,
		input logic [4:0]  addr,
		input logic [15:0] rate,
		input logic [15:0] temp
	);
		logic [15:0] word;
		word = DATA_RESET;
		if (!wr && addr == ADDR_RATE) begin
			word = rate;
		end else if (!wr && addr == ADDR_TEMP) begin
			word = temp;
		end
		return word;
	endfunction : read_word

	// ---------------- Link domain ----------------

	// Bit counter is held clear while the chip select is high
	always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			bit_cnt_r <= 6'h00;
		end else if (bit_cnt_r != BIT_CNT_MAX) begin
			bit_cnt_r <= bit_cnt_r + 6'h01;
		end
	end

	always_comb begin
		link_nxt       = link_r;
		link_nxt.shift = {link_r.shift[30:0], mosi_in};
		// Frame is complete only on exactly the 32nd edge; longer frames drop it
		link_nxt.full  = (bit_cnt_r == BIT_CNT_LAST);
		if (bit_cnt_r == BIT_CNT_LAST) begin
			link_nxt.frame = gsf_frame_s'({link_r.shift[30:0], mosi_in});
		end
		// Take the sealed response once per frame; it is quiet by the end of the frame gap
		if (bit_cnt_r == 6'h00) begin
			link_nxt.tx = sys_r.resp[30:0];
		end
	end

	// No reset here: this clock only runs inside frames
	always_ff @(posedge spi_clk_in) begin
		link_r <= link_nxt;
	end

	// Output changes on the falling edge so the master samples it on the rising one
	always_ff @(negedge spi_clk_in) begin
		if (cs_n_in) begin
			miso_r <= miso_r;
		end else if (bit_cnt_r == BIT_CNT_FULL) begin
			// Write flag of the next response is this request's own bit 31
			miso_r <= link_r.shift[31];
		end else if (bit_cnt_r != 6'h00 && bit_cnt_r < BIT_CNT_FULL) begin
			miso_r <= link_r.tx[tx_index(bit_cnt_r)];
		end else begin
			miso_r <= miso_r;
		end
	end

	// ---------------- System domain ----------------

	gsf_crc8 u_req_crc (
		.data_in (sys_r.req[31:8]),
		.crc_out (req_crc)
	);

	gsf_crc8 u_resp_crc (
		.data_in (sys_r.body),
		.crc_out (resp_crc)
	);

	always_comb begin
		logic crc_match;
		logic fault;
		crc_match = 1'b0;
		fault     = 1'b0;
		sys_nxt   = sys_r;

		sys_nxt.cs_sync = {sys_r.cs_sync[0], cs_n_in};
		sys_nxt.cs_prev = sys_r.cs_sync[1];
		sys_nxt.wr_stb  = 1'b0;

		sys_nxt.ok.ok_common = &common_ok_flags_in;
		sys_nxt.ok.ok_rate   = (&rate1_ok_flags_in) & (&rate2_ok_flags_in);
		sys_nxt.ok.ok_acc    = &acc_ok_flags_in;

		// Stage 1: end of frame seen, latch the request from the quiet link side
		if (sys_r.cs_sync[1] && !sys_r.cs_prev && link_r.full) begin
			sys_nxt.req  = link_r.frame;
			sys_nxt.pend = 1'b1;
		end else begin
			sys_nxt.pend = 1'b0;
		end

		// Stage 2: check the request, build the response body
		if (sys_r.pend) begin
			crc_match       = (req_crc == sys_r.req.crc);
			// A bad request checksum is reported like any other error
			fault           = !addr_exists(sys_r.req.addr)
				|| channel_fault(sys_r.req.addr, sys_r.ok)
				|| !crc_match;
			sys_nxt.crc_err = !crc_match;
			sys_nxt.body    = {sys_r.req.wr, sys_r.req.addr,
				status_code(self_test_in, init_busy_in, fault),
				read_word(sys_r.req.wr, sys_r.req.addr, angular_rate_in, temperature_in)};
			if (sys_r.req.wr && crc_match) begin
				sys_nxt.wr_stb  = 1'b1;
				sys_nxt.wr_addr = sys_r.req.addr;
				sys_nxt.wr_data = sys_r.req.data;
			end
		end

		// Stage 3: seal the response with its checksum
		sys_nxt.resp = gsf_frame_s'({sys_r.body, resp_crc});

		if (reset_in) begin
			sys_nxt.cs_sync    = 2'h3;
			sys_nxt.cs_prev    = 1'b1;
			sys_nxt.pend       = 1'b0;
			sys_nxt.req        = '0;
			sys_nxt.body       = '0;
			sys_nxt.resp       = '0;
			sys_nxt.wr_stb     = 1'b0;
			sys_nxt.wr_addr    = 5'h00;
			sys_nxt.wr_data    = DATA_RESET;
			sys_nxt.ok         = gsf_ok_s'(OK_RESET);
			sys_nxt.crc_err    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		sys_r <= sys_nxt;
	end

	assign miso_out         = miso_r;
	assign write_strobe_out = sys_r.wr_stb;
	assign write_addr_out   = sys_r.wr_addr;
	assign write_data_out   = sys_r.wr_data;
	assign status_ok_out    = sys_r.ok;
	assign crc_error_out    = sys_r.crc_err;

endmodule : gsf_frontend

// file: gsf_frontend_monitor.sv
// Checker for the rate sensor SPI frontend, bound to every gsf_frontend.
// Assumes the SPI pins are judged by the bench; only sys-domain relations here.
`timescale 1ns/10ps
module gsf_frontend_monitor
	import gsf_pkg::*;
#(
	parameter int COMMON_FLAGS = 8,
	parameter int RATE1_FLAGS  = 8,
	parameter int RATE2_FLAGS  = 8,
	parameter int ACC_FLAGS    = 8
) (
	input wire logic                    clk_sys_in,
	input wire logic                    reset_in,
	input wire logic                    cs_n_in,
	input wire logic [COMMON_FLAGS-1:0] common_ok_flags_in,
	input wire logic [RATE1_FLAGS-1:0]  rate1_ok_flags_in,
	input wire logic [RATE2_FLAGS-1:0]  rate2_ok_flags_in,
	input wire logic [ACC_FLAGS-1:0]    acc_ok_flags_in,
	input wire logic                    write_strobe_out,
	input wire logic [4:0]              write_addr_out,
	input wire logic [15:0]             write_data_out,
	input wire logic [2:0]              status_ok_out,
	input wire logic                    crc_error_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	AST_OK_COMMON: assert property (!$past(reset_in) |-> status_ok_out[2] == $past(&common_ok_flags_in))
		else $error("common ok summary wrong");
	AST_OK_RATE: assert property (!$past(reset_in) |->
		status_ok_out[1] == $past(&rate1_ok_flags_in & &rate2_ok_flags_in)) else $error("rate ok summary wrong");
	AST_OK_ACC: assert property (!$past(reset_in) |-> status_ok_out[0] == $past(&acc_ok_flags_in))
		else $error("acc ok summary wrong");
	AST_STROBE_GAP: assert property (write_strobe_out |=> !write_strobe_out [*8])
		else $error("write strobe too long");
	AST_STROBE_CS: assert property (write_strobe_out |-> cs_n_in && $past(cs_n_in, 3))
		else $error("write strobe inside a frame");
	AST_STROBE_CRC: assert property (write_strobe_out |-> !crc_error_out)
		else $error("write despite bad checksum");
	AST_WR_HOLD: assert property (!write_strobe_out |-> $stable({write_addr_out, write_data_out}))
		else $error("write fields moved");
	AST_CRCERR_CS: assert property ($changed(crc_error_out) |-> cs_n_in)
		else $error("checksum flag moved in frame");
	COV_WRITE: cover property (write_strobe_out);
	COV_BAD_CRC: cover property ($rose(crc_error_out));
	COV_NOT_OK: cover property (status_ok_out != 3'h7);
endmodule : gsf_frontend_monitor

bind gsf_frontend gsf_frontend_monitor #(
	.COMMON_FLAGS(COMMON_FLAGS), .RATE1_FLAGS(RATE1_FLAGS), .RATE2_FLAGS(RATE2_FLAGS), .ACC_FLAGS(ACC_FLAGS)
) gsf_frontend_monitor_i (
	.clk_sys_in, .reset_in, .cs_n_in, .common_ok_flags_in, .rate1_ok_flags_in, .rate2_ok_flags_in,
	.acc_ok_flags_in, .write_strobe_out, .write_addr_out, .write_data_out, .status_ok_out, .crc_error_out
);

// file: gsf_spi_master.sv
// SPI master model: 32-bit mode 0 frames, MSB first, sealed with CRC-8.
// Assumes the bench calls xfer and crc8 hierarchically, one frame at a time.
`timescale 1ns/10ps
module gsf_spi_master (
	output logic      spi_clk_out,
	output logic      cs_n_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	// 160 ns SCK, under the 8 MHz ceiling
	localparam int HALF = 80;
	initial begin
		spi_clk_out = 1'b0;
		cs_n_out    = 1'b0;
		mosi_out    = 1'b0;
		// A real rising edge clears the slave's bit counter before the first frame
		#1 cs_n_out = 1'b1;
	end
	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
		end
		return ~c;
	endfunction : crc8
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		#13 cs_n_out = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			mosi_out = tx[i];
			#HALF spi_clk_out = 1'b1;
			rx[i] = miso_in;
			#HALF spi_clk_out = 1'b0;
		end
		#HALF cs_n_out = 1'b1;
		// Deselected line shows the inverse, never a stale bit
		mosi_out = ~mosi_out;
		#200;
	endtask : xfer
endmodule : gsf_spi_master

// file: gsf_frontend_test.sv
// Self-checking bench for the rate sensor SPI frontend driven by the master model.
// Assumes off-frame answers; the first answer after reset is discarded.
`timescale 1ns/10ps
module gsf_frontend_test
	import gsf_pkg::*;
;
	logic        clk_sys_in         = 1'b0;
	logic        reset_in           = 1'b1;
	wire         spi_clk_in, cs_n_in, mosi_in, miso_out;
	logic [15:0] angular_rate_in    = 16'hFFE0;
	logic [15:0] temperature_in     = 16'hFE6F;
	logic        init_busy_in       = 1'b0;
	logic        self_test_in       = 1'b0;
	logic [7:0]  common_ok_flags_in = 8'hFF;
	logic [7:0]  rate1_ok_flags_in  = 8'hFF;
	logic [7:0]  rate2_ok_flags_in  = 8'hFF;
	logic [7:0]  acc_ok_flags_in    = 8'hFF;
	logic        write_strobe_out, crc_error_out;
	logic [4:0]  write_addr_out;
	logic [15:0] write_data_out;
	logic [2:0]  status_ok_out;
	logic [31:0] rx;
	logic [1:0]  pexp;
	logic [20:0] wr_seen;
	int          error_cnt = 0, total_checks = 0, n_wr = 0;
	gsf_frontend gsf_frontend_i (
		.clk_sys_in, .reset_in, .spi_clk_in, .cs_n_in, .mosi_in, .miso_out, .angular_rate_in, .temperature_in,
		.init_busy_in, .self_test_in, .common_ok_flags_in, .rate1_ok_flags_in, .rate2_ok_flags_in,
		.acc_ok_flags_in, .write_strobe_out, .write_addr_out, .write_data_out, .status_ok_out, .crc_error_out
	);
	gsf_spi_master gsf_spi_master_i (.spi_clk_out(spi_clk_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in), .miso_in(miso_out));
	always #5 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) begin
		if (write_strobe_out === 1'b1) begin
			n_wr++;
			wr_seen = {write_addr_out, write_data_out};
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [5:0] op, input logic [15:0] d, input logic bad);
		logic [31:0] tx;
		tx = {op, 2'h0, d, 8'h00};
		tx[7:0] = gsf_spi_master_i.crc8(tx[31:8]) ^ {7'h0, bad};
		gsf_spi_master_i.xfer(tx, rx);
	endtask : send
	task automatic setf(input logic [5:0] s);
		@(posedge clk_sys_in);
		self_test_in       <= s[5];
		init_busy_in       <= s[4];
		common_ok_flags_in <= s[0] ? 8'hEF : 8'hFF;
		rate1_ok_flags_in  <= s[1] ? 8'hFE : 8'hFF;
		rate2_ok_flags_in  <= s[2] ? 8'h7F : 8'hFF;
		acc_ok_flags_in    <= s[3] ? 8'hFB : 8'hFF;
		repeat (2) @(negedge clk_sys_in);
		chk(status_ok_out, {~s[0], ~(s[1] | s[2]), ~s[3]});
	endtask : setf
	// Checks the answer to the previous request, then queues this one's
	task automatic step(input logic [5:0] op, input logic [15:0] d, input logic bad, input logic [5:0] s,
		input logic [1:0] e);
		setf(s);
		send(op, d, bad);
		chk(rx[25:24], pexp);
		chk(rx[7:0], gsf_spi_master_i.crc8(rx[31:8]));
		pexp = e;
	endtask : step
	task automatic t_data();
		send({1'b0, ADDR_RATE}, 16'h0000, 1'b0);
		send({1'b0, ADDR_TEMP}, 16'h0000, 1'b0);
		chk(rx, 32'h05FFE08B);
		send(6'h1F, 16'h0000, 1'b0);
		chk(rx, 32'h1DFE6F4E);
		pexp = RS_NORMAL;
	endtask : t_data
	task automatic t_prio();
		for (int k = 0; k < 8; k++) begin
			step({1'b0, ADDR_RATE}, 16'h0000, 1'b0, {k[2], k[1], 3'h0, k[0]},
				k[2] ? RS_SELFTEST : k[1] ? RS_INIT : k[0] ? RS_ERROR : RS_NORMAL);
		end
	endtask : t_prio
	task automatic t_chan();
		step(6'h02, 16'h0000, 1'b0, 6'h00, RS_ERROR);
		step({1'b0, ADDR_ACC_STATUS}, 16'h0000, 1'b0, 6'h08, RS_ERROR);
		step({1'b0, ADDR_RATE}, 16'h0000, 1'b0, 6'h08, RS_NORMAL);
		step({1'b0, ADDR_RATE}, 16'h0000, 1'b0, 6'h04, RS_ERROR);
		step({1'b0, ADDR_ACC_STATUS}, 16'h0000, 1'b0, 6'h02, RS_NORMAL);
		step(6'h09, 16'h0000, 1'b0, 6'h00, RS_NORMAL);
		step(6'h11, 16'h0000, 1'b0, 6'h00, RS_ERROR);
	endtask : t_chan
	task automatic t_write();
		int n0;
		n0 = n_wr;
		step(6'h36, 16'h0A5C, 1'b0, 6'h00, RS_NORMAL);
		chk(n_wr - n0, 1);
		chk(wr_seen, {5'h16, 16'h0A5C});
		step(6'h36, 16'h1234, 1'b1, 6'h00, RS_ERROR);
		@(negedge clk_sys_in);
		chk(n_wr - n0, 1);
		chk(crc_error_out, 1'b1);
		step({1'b0, ADDR_RATE}, 16'h0000, 1'b0, 6'h00, RS_NORMAL);
		@(negedge clk_sys_in);
		chk(crc_error_out, 1'b0);
		step({1'b0, ADDR_RATE}, 16'h0000, 1'b0, 6'h00, RS_NORMAL);
	endtask : t_write
	task automatic summarize();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (8) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_data();
		t_prio();
		t_chan();
		t_write();
		summarize();
	end
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
endmodule : gsf_frontend_test
